// ==== tap_pkg.sv ====
// Constants and types for the boundary-scan test access port.
// Used by the port core, its state machine and the bench; the state machine is on the test clock, the core on the test clock and clk.
package tap_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register widths
   localparam int IR_W  = 8;
   localparam int BSR_W = 48;
   localparam int BCR_W = 3;
   localparam int ID_W  = 32;

   ////////////////////////////////////////////////////////////////////////////
   // Instruction opcodes, bit 7 is the even-parity bit
   localparam logic [IR_W-1:0] IR_CAPTURE = 8'h81;
   localparam logic [IR_W-1:0] IR_IDCODE  = 8'h81;
   localparam logic [IR_W-1:0] IR_BYPASS  = 8'hFF;
   localparam logic [IR_W-1:0] IR_EXTEST  = 8'h00;
   localparam logic [IR_W-1:0] IR_SAMPLE  = 8'h82;
   localparam logic [IR_W-1:0] IR_BCRSCAN = 8'h87;
   localparam logic [IR_W-1:0] IR_RUNTEST = 8'h09;

   ////////////////////////////////////////////////////////////////////////////
   // Boundary-control operations and reset values
   localparam logic [BCR_W-1:0] BCR_RESET  = 3'h2;
   localparam logic [BCR_W-1:0] BCR_SIGN   = 3'h2;
   localparam logic [BCR_W-1:0] BCR_TOGGLE = 3'h1;
   localparam logic [BCR_W-1:0] BCR_PRPG   = 3'h3;
   localparam logic [BCR_W-1:0] BCR_COUNT  = 3'h6;
   localparam int               BSR_SAFE_LO  = 44;
   localparam int               BSR_SAFE_HI  = 47;
   localparam logic [3:0]       BSR_SAFE_VAL = 4'hF;
   // Feedback taps of the signature and pattern register
   localparam int               TAP_A = 0;
   localparam int               TAP_B = 1;
   localparam int               TAP_C = 26;
   localparam int               TAP_D = 27;

   ////////////////////////////////////////////////////////////////////////////
   // Controller states, one-hot
   typedef enum logic [15:0] {
      stReset = 16'h0001, stIdle  = 16'h0002, stSelDr = 16'h0004, stCapDr = 16'h0008,
      stShDr  = 16'h0010, stEx1Dr = 16'h0020, stPauDr = 16'h0040, stEx2Dr = 16'h0080,
      stUpdDr = 16'h0100, stSelIr = 16'h0200, stCapIr = 16'h0400, stShIr  = 16'h0800,
      stEx1Ir = 16'h1000, stPauIr = 16'h2000, stEx2Ir = 16'h4000, stUpdIr = 16'h8000
   } tap_state_t;

   // Data register selected for the scan path, one-hot
   typedef enum logic [3:0] {
      drBoundary = 4'h1,
      drControl  = 4'h2,
      drBypass   = 4'h4,
      drIdent    = 4'h8
   } dr_sel_t;

   // Meaning of the current instruction
   typedef struct packed {
      dr_sel_t dr;
      logic    testMode;
      logic    runOps;
   } instr_dec_t;

endpackage

// ==== tap_ctrl_if.sv ====
// Link between the port core and its state machine.
// Assumes both ends sit on the test clock.
`timescale 1ns/1ns
interface tap_ctrl_if;
   logic               tms;
   logic               resetReq;
   tap_pkg::tap_state_t state;

   modport fsm  (input tms, input resetReq, output state);
   modport core (output tms, output resetReq, input state);
endinterface

// ==== tap_fsm.sv ====
// Sixteen-state controller of the test access port.
// Assumes tms is stable at each rising tck edge and resetReq is on tck.
`timescale 1ns/1ns
module tap_fsm (
   input wire logic tck,
   tap_ctrl_if.fsm  ctrl
);
   typedef struct packed {
      tap_pkg::tap_state_t state;
   } fsm_reg_t;

   fsm_reg_t fsm_r;
   fsm_reg_t fsm_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // Next state from the tms level at the rising edge
   always_comb begin
      fsm_nxt = fsm_r;
      case (fsm_r.state)
         tap_pkg::stReset: fsm_nxt.state = ctrl.tms ? tap_pkg::stReset : tap_pkg::stIdle;
         tap_pkg::stIdle:  fsm_nxt.state = ctrl.tms ? tap_pkg::stSelDr : tap_pkg::stIdle;
         tap_pkg::stSelDr: fsm_nxt.state = ctrl.tms ? tap_pkg::stSelIr : tap_pkg::stCapDr;
         tap_pkg::stCapDr: fsm_nxt.state = ctrl.tms ? tap_pkg::stEx1Dr : tap_pkg::stShDr;
         tap_pkg::stShDr:  fsm_nxt.state = ctrl.tms ? tap_pkg::stEx1Dr : tap_pkg::stShDr;
         tap_pkg::stEx1Dr: fsm_nxt.state = ctrl.tms ? tap_pkg::stUpdDr : tap_pkg::stPauDr;
         tap_pkg::stPauDr: fsm_nxt.state = ctrl.tms ? tap_pkg::stEx2Dr : tap_pkg::stPauDr;
         tap_pkg::stEx2Dr: fsm_nxt.state = ctrl.tms ? tap_pkg::stUpdDr : tap_pkg::stShDr;
         tap_pkg::stUpdDr: fsm_nxt.state = ctrl.tms ? tap_pkg::stSelDr : tap_pkg::stIdle;
         tap_pkg::stSelIr: fsm_nxt.state = ctrl.tms ? tap_pkg::stReset : tap_pkg::stCapIr;
         tap_pkg::stCapIr: fsm_nxt.state = ctrl.tms ? tap_pkg::stEx1Ir : tap_pkg::stShIr;
         tap_pkg::stShIr:  fsm_nxt.state = ctrl.tms ? tap_pkg::stEx1Ir : tap_pkg::stShIr;
         tap_pkg::stEx1Ir: fsm_nxt.state = ctrl.tms ? tap_pkg::stUpdIr : tap_pkg::stPauIr;
         tap_pkg::stPauIr: fsm_nxt.state = ctrl.tms ? tap_pkg::stEx2Ir : tap_pkg::stPauIr;
         tap_pkg::stEx2Ir: fsm_nxt.state = ctrl.tms ? tap_pkg::stUpdIr : tap_pkg::stShIr;
         tap_pkg::stUpdIr: fsm_nxt.state = ctrl.tms ? tap_pkg::stSelDr : tap_pkg::stIdle;
         // Illegal codes recover through reset, like a floating high tms would
         default:          fsm_nxt.state = tap_pkg::stReset;
      endcase
      if (ctrl.resetReq) begin
         fsm_nxt.state = tap_pkg::stReset;
      end
   end

   // State register, rising edge only
   always_ff @(posedge tck) begin
      fsm_r <= fsm_nxt;
   end

   assign ctrl.state = fsm_r.state;
endmodule

// ==== scan_tap.sv ====
// Test access port core: instruction and data registers, serial output,
// run-test operations and crossing of the test-mode flags to clk.
// Assumes tck, tms and tdi come from the board test controller, with
// tms and tdi pulled high at the pad, and bcIn from the transceiver pins.
//
// Notes on behaviour
// - Test logic on tck: sample on rising edge, outputs change on falling.
// - tdi feeds the instruction register or the selected data register.
// - tdo shows the serial output of the register in the scan path.
// - Controller sees only tck, tms and the synchronised rst and makes all register controls.
// - Registers: 8-bit instruction, 48 boundary, 3 control, 1 bypass, 32 ident.
// - Next state follows tms at each rising tck; host sets tms before it.
// - Sixteen states; six may be held, ten always left after one cycle.
// - Separate data and instruction paths; one register scanned at a time.
// - At power-up the controller starts in test-logic reset.
// - In test-logic reset the test logic is off; transceiver works normally.
// - Holding tms high reaches test-logic reset within five tck cycles.
// - Entering reset loads instruction 10000001, the identification instruction.
// - Reset sets boundary cells 47 to 44 high, leaving outputs off in test.
// - Other boundary cells have no defined reset value.
// - Reset loads the control register with 010, signature analysis.
// - Leaving reset passes run-test/idle before any test operation runs.
// - Run-test/idle follows either scan and may be held indefinitely.
// - The control register's operation runs only while in run-test/idle.
// - Unconnected tms or tdi reads high; floating tms drives reset.
// - First falling edge in a shift state enables tdo with the register lsb.
// - First falling edge in exit-1 of either path turns tdo off.
// - New instruction takes effect on the falling edge in update-IR.
// - Bit 7 is even parity; unsupported opcodes behave as bypass.
`timescale 1ns/1ns
module scan_tap #(
   parameter logic [31:0] IDCODE_VAL = 32'h00001001  // Arbitrary value, lsb must be one
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        tck,
   input  wire logic        tms,
   input  wire logic        tdi,
   output logic             tdo,
   output logic             tdoOe,
   input  wire logic [47:0] bcIn,
   output logic      [47:0] bcOut,
   output logic             testMode,
   output logic             testRunning
);

   ////////////////////////////////////////////////////////////////////////////
   // State types, one per clock edge group

   // Rising-edge tck state: shift stages and synchronisers
   typedef struct packed {
      logic                            rstMeta;
      logic                            rstSync;
      logic [tap_pkg::BSR_W-1:0]       pinMeta;
      logic [tap_pkg::BSR_W-1:0]       pinSync;
      logic [tap_pkg::IR_W-1:0]        irShift;
      logic [tap_pkg::BSR_W-1:0]       bsrShift;
      logic [tap_pkg::BCR_W-1:0]       bcrShift;
      logic                            bypass;
      logic [tap_pkg::ID_W-1:0]        idShift;
      logic                            opRun;
   } rise_reg_t;

   // Falling-edge tck state: shadows and the serial output
   typedef struct packed {
      logic [tap_pkg::IR_W-1:0]        irCur;
      logic [tap_pkg::BSR_W-1:0]       bsrShadow;
      logic [tap_pkg::BCR_W-1:0]       bcrShadow;
      logic                            tdo;
      logic                            tdoOe;
      logic                            testMode;
   } fall_reg_t;

   // clk state: level synchronisers for the test-mode flags
   typedef struct packed {
      logic                            tmMeta;
      logic                            tmSync;
      logic                            runMeta;
      logic                            runSync;
   } sys_reg_t;

   rise_reg_t           rise_r;
   rise_reg_t           rise_nxt;
   fall_reg_t           fall_r;
   fall_reg_t           fall_nxt;
   sys_reg_t            sys_r;
   sys_reg_t            sys_nxt;
   tap_pkg::tap_state_t st;
   tap_pkg::instr_dec_t dec;
   logic                lfsrFb;

   ////////////////////////////////////////////////////////////////////////////
   // Instruction decode, used for the current instruction and its update

   function automatic tap_pkg::instr_dec_t decodeInstr(input logic [tap_pkg::IR_W-1:0] op);
      tap_pkg::instr_dec_t d;
      d.dr       = tap_pkg::drBypass;
      d.testMode = 1'b0;
      d.runOps   = 1'b0;
      // A parity failure or an unknown opcode falls back to bypass
      if (^op == 1'b0) begin
         case (op)
            tap_pkg::IR_EXTEST: begin
               d.dr       = tap_pkg::drBoundary;
               d.testMode = 1'b1;
            end
            tap_pkg::IR_SAMPLE: begin
               d.dr = tap_pkg::drBoundary;
            end
            tap_pkg::IR_IDCODE: begin
               d.dr = tap_pkg::drIdent;
            end
            tap_pkg::IR_BCRSCAN: begin
               d.dr = tap_pkg::drControl;
            end
            tap_pkg::IR_RUNTEST: begin
               d.testMode = 1'b1;
               d.runOps   = 1'b1;
            end
            default: begin
               d.dr = tap_pkg::drBypass;
            end
         endcase
      end
      return d;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Controller

   tap_ctrl_if ctrl ();

   // Only tck, tms and the synchronised rst reach the controller; a floating tms reads high
   assign ctrl.tms      = tms;
   assign ctrl.resetReq = rise_r.rstSync;
   assign st            = ctrl.state;

   tap_fsm fsm (
      .tck  (tck),
      .ctrl (ctrl.fsm)
   );

   assign dec    = decodeInstr(fall_r.irCur);
   assign lfsrFb = rise_r.bsrShift[tap_pkg::TAP_A] ^ rise_r.bsrShift[tap_pkg::TAP_B]
                 ^ rise_r.bsrShift[tap_pkg::TAP_C] ^ rise_r.bsrShift[tap_pkg::TAP_D];

   ////////////////////////////////////////////////////////////////////////////
   // Rising edge: capture, shift and run-test operations

   always_comb begin
      rise_nxt = rise_r;
      // The reset level and pins come from other domains, two stages each
      rise_nxt.rstMeta = rst;
      rise_nxt.rstSync = rise_r.rstMeta;
      rise_nxt.pinMeta = bcIn;
      rise_nxt.pinSync = rise_r.pinMeta;
      rise_nxt.opRun   = 1'b0;
      if (rise_r.rstSync) begin
         // Only the safe cells are defined; the rest keep whatever they hold
         rise_nxt.irShift  = tap_pkg::IR_CAPTURE;
         rise_nxt.bsrShift[tap_pkg::BSR_SAFE_HI:tap_pkg::BSR_SAFE_LO] = tap_pkg::BSR_SAFE_VAL;
         rise_nxt.bcrShift = tap_pkg::BCR_RESET;
         rise_nxt.bypass   = 1'b0;
         rise_nxt.idShift  = IDCODE_VAL;
      end else begin
         case (st)
            // Instruction path
            tap_pkg::stCapIr: begin
               rise_nxt.irShift = tap_pkg::IR_CAPTURE;
            end
            tap_pkg::stShIr: begin
               rise_nxt.irShift = {tdi, rise_r.irShift[tap_pkg::IR_W-1:1]};
            end
            // Data path: only the selected register moves
            tap_pkg::stCapDr: begin
               case (dec.dr)
                  tap_pkg::drBoundary: rise_nxt.bsrShift = rise_r.pinSync;
                  tap_pkg::drControl:  rise_nxt.bcrShift = fall_r.bcrShadow;
                  tap_pkg::drIdent:    rise_nxt.idShift  = IDCODE_VAL;
                  default:             rise_nxt.bypass   = 1'b0;
               endcase
            end
            tap_pkg::stShDr: begin
               case (dec.dr)
                  tap_pkg::drBoundary: rise_nxt.bsrShift = {tdi, rise_r.bsrShift[tap_pkg::BSR_W-1:1]};
                  tap_pkg::drControl:  rise_nxt.bcrShift = {tdi, rise_r.bcrShift[tap_pkg::BCR_W-1:1]};
                  tap_pkg::drIdent:    rise_nxt.idShift  = {tdi, rise_r.idShift[tap_pkg::ID_W-1:1]};
                  default:             rise_nxt.bypass   = tdi;
               endcase
            end
            // Test operations act only while idling under the run instruction
            tap_pkg::stIdle: begin
               if (dec.runOps) begin
                  rise_nxt.opRun = 1'b1;
                  case (fall_r.bcrShadow)
                     tap_pkg::BCR_SIGN: begin
                        rise_nxt.bsrShift = {lfsrFb, rise_r.bsrShift[tap_pkg::BSR_W-1:1]}
                                          ^ rise_r.pinSync;
                     end
                     tap_pkg::BCR_PRPG: begin
                        rise_nxt.bsrShift = {lfsrFb, rise_r.bsrShift[tap_pkg::BSR_W-1:1]};
                     end
                     tap_pkg::BCR_COUNT: begin
                        rise_nxt.bsrShift = rise_r.bsrShift + 48'h000000000001;
                     end
                     tap_pkg::BCR_TOGGLE: begin
                        rise_nxt.bsrShift = ~rise_r.bsrShift;
                     end
                     default: begin
                        rise_nxt.opRun = 1'b0;
                     end
                  endcase
               end
            end
            default: begin
               rise_nxt.opRun = 1'b0;
            end
         endcase
      end
   end

   // Inputs are taken on the rising tck edge
   always_ff @(posedge tck) begin
      rise_r <= rise_nxt;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Falling edge: updates, reset of shadows and the serial output

   always_comb begin
      fall_nxt = fall_r;
      // Driving only in shift states keeps a shared tdo line free otherwise
      fall_nxt.tdoOe = (st == tap_pkg::stShDr) || (st == tap_pkg::stShIr);
      fall_nxt.tdo   = 1'b0;
      if (st == tap_pkg::stShIr) begin
         fall_nxt.tdo = rise_r.irShift[0];
      end else if (st == tap_pkg::stShDr) begin
         case (dec.dr)
            tap_pkg::drBoundary: fall_nxt.tdo = rise_r.bsrShift[0];
            tap_pkg::drControl:  fall_nxt.tdo = rise_r.bcrShift[0];
            tap_pkg::drIdent:    fall_nxt.tdo = rise_r.idShift[0];
            default:             fall_nxt.tdo = rise_r.bypass;
         endcase
      end
      case (st)
         tap_pkg::stReset: begin
            fall_nxt.irCur     = tap_pkg::IR_IDCODE;
            fall_nxt.bcrShadow = tap_pkg::BCR_RESET;
            fall_nxt.bsrShadow[tap_pkg::BSR_SAFE_HI:tap_pkg::BSR_SAFE_LO] = tap_pkg::BSR_SAFE_VAL;
         end
         tap_pkg::stUpdIr: begin
            fall_nxt.irCur = rise_r.irShift;
         end
         tap_pkg::stUpdDr: begin
            if (dec.dr == tap_pkg::drBoundary) begin
               fall_nxt.bsrShadow = rise_r.bsrShift;
            end else if (dec.dr == tap_pkg::drControl) begin
               fall_nxt.bcrShadow = rise_r.bcrShift;
            end
         end
         default: begin
            fall_nxt.irCur = fall_r.irCur;
         end
      endcase
      // Normal function is untouched while in reset
      fall_nxt.testMode = decodeInstr(fall_nxt.irCur).testMode
                        && (st != tap_pkg::stReset);
   end

   // Outputs change on the falling tck edge
   always_ff @(negedge tck) begin
      fall_r <= fall_nxt;
   end

   assign tdo   = fall_r.tdo;
   assign tdoOe = fall_r.tdoOe;
   assign bcOut = fall_r.bsrShadow;

   ////////////////////////////////////////////////////////////////////////////
   // clk side: level crossings of the test-mode flags

   always_comb begin
      sys_nxt         = sys_r;
      sys_nxt.tmMeta  = fall_r.testMode;
      sys_nxt.tmSync  = sys_r.tmMeta;
      sys_nxt.runMeta = rise_r.opRun;
      sys_nxt.runSync = sys_r.runMeta;
      if (rst) begin
         sys_nxt = '0;
      end
   end

   // Levels only: a single run cycle shorter than one clk period may be missed
   always_ff @(posedge clk) begin
      sys_r <= sys_nxt;
   end

   assign testMode    = sys_r.tmSync;
   assign testRunning = sys_r.runSync;

endmodule

// ==== scan_tap_props.sv ====
// Checker of the test access port, seeing only the pins of scan_tap.
// Assumes tck toggles during rst so the two-flop reset crossing settles.
`timescale 1ns/1ns
module scan_tap_props #(
   parameter logic [31:0] IDCODE_VAL = 32'h00001001
) (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        tck,
   input wire logic        tms,
   input wire logic        tdi,
   input wire logic        tdo,
   input wire logic        tdoOe,
   input wire logic [47:0] bcIn,
   input wire logic [47:0] bcOut,
   input wire logic        testMode,
   input wire logic        testRunning
);
   // Next state per nibble: tms low, tms high
   localparam logic [63:0] NXT0 = 64'h1BDDBBA146644311;
   localparam logic [63:0] NXT1 = 64'h2FEFCC0287855920;
   logic [3:0] st_r;
   logic [1:0] rsSync_r;
   logic       idSel_r;
   logic       inShift;
   ////////////////////////////////////////
   // Shadow controller; tracks tms itself so a wrong graph in the design shows
   always_ff @(posedge tck) begin
      rsSync_r <= {rsSync_r[0], rst};
      st_r     <= rsSync_r[1] ? 4'h0 : (tms ? NXT1[st_r*4 +: 4] : NXT0[st_r*4 +: 4]);
      idSel_r  <= (rsSync_r[1] || st_r == 4'h0) ? 1'h1 : ((st_r == 4'hF) ? 1'h0 : idSel_r);
   end
   assign inShift = (st_r == 4'h4) || (st_r == 4'hB);
   ////////////////////////////////////////
   a_oe_in_shift: assert property (
      @(posedge tck) disable iff (rst || rsSync_r[1]) inShift |-> tdoOe)
      else $error("tdo not driven in shift");
   a_tdo_off_else: assert property (
      @(posedge tck) disable iff (rst || rsSync_r[1]) !inShift |-> !tdoOe && !tdo)
      else $error("tdo driven outside shift");
   a_ir_capture_out: assert property (
      @(posedge tck) disable iff (rst || rsSync_r[1])
      (st_r == 4'hA) ##1 (st_r == 4'hB && !tms) |-> tdo ##1 !tdo)
      else $error("instruction capture not 10000001");
   a_id_lsb_first: assert property (
      @(posedge tck) disable iff (rst || rsSync_r[1])
      (st_r == 4'h3 && idSel_r) ##1 (st_r == 4'h4 && !tms) |-> tdo == IDCODE_VAL[0] ##1 tdo == IDCODE_VAL[1])
      else $error("ident not first out");
   a_reset_cells_safe: assert property (
      @(posedge tck) disable iff (rst || rsSync_r[1]) (st_r == 4'h0) [*2] |-> bcOut[47:44] == 4'hF)
      else $error("cells 47 to 44 not high in reset");
   a_reset_mode_off: assert property (
      @(posedge tck) disable iff (rst || rsSync_r[1]) (st_r == 4'h0) [*8] |-> !testMode)
      else $error("test mode in reset");
   a_ops_idle_only: assert property (
      @(posedge tck) disable iff (rst || rsSync_r[1]) (st_r != 4'h1) [*8] |-> !testRunning)
      else $error("operation outside idle");
   a_run_in_test: assert property (
      @(posedge clk) disable iff (rst) testRunning |-> testMode)
      else $error("operation in normal mode");
   c_ir_scan: cover property (@(posedge tck) st_r == 4'hB ##1 st_r == 4'hC);
   c_dr_scan: cover property (@(posedge tck) st_r == 4'h4 ##1 st_r == 4'h5);
   c_running: cover property (@(posedge clk) testRunning);
endmodule
bind scan_tap scan_tap_props #(.IDCODE_VAL(IDCODE_VAL)) props (.clk(clk), .rst(rst), .tck(tck), .tms(tms),
   .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe), .bcIn(bcIn), .bcOut(bcOut), .testMode(testMode), .testRunning(testRunning));

// ==== tap_host_model.sv ====
// Board test controller model driving the test access port.
// Assumes tdo settles within half a tck period after each falling edge.
`timescale 1ns/1ns
module tap_host_model (
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo,
   input  wire logic tdoOe
);
   // Idle bus: tms and tdi high as if floating on their pull-ups
   initial begin
      tck = 1'h0;
      tms = 1'h1;
      tdi = 1'h1;
   end
   ////////////////////////////////////////
   // One tck cycle; tck stands still between calls
   task automatic step(input logic m, input logic d, output logic o);
      tms = m; // Set half a period before the rising edge
      tdi = d;
      #15;
      o = tdo;
      tck = 1'h1;
      #15;
      tck = 1'h0;
   endtask
   // Cycles with tdi not meaningful; it toggles so a stale value never helps
   task automatic run(input int n, input logic m);
      logic o;
      repeat (n) step(m, ~tdi, o);
   endtask
   // Idle to idle scan, n bits lsb first
   task automatic scan(input logic ir, input logic [63:0] din, input int n, output logic [63:0] dout);
      logic o;
      dout = '0;
      run(1, 1'h1);
      if (ir) run(1, 1'h1);
      run(2, 1'h0);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], o);
         dout[i] = o;
      end
      run(1, 1'h1);
      run(1, 1'h0);
   endtask
endmodule

// ==== tb_scan_tap.sv ====
// Self-checking bench of scan_tap with the board controller model.
// Assumes the package, design, checker and host model are compiled first.
`timescale 1ns/1ns
module tb_scan_tap;
   localparam logic [31:0] ID_VAL = 32'h5A3C96E1; // Arbitrary, lsb one
   logic        clk, rst, tck, tms, tdi, tdo, tdoOe, testMode, testRunning;
   logic [47:0] bcIn, bcOut;
   logic [63:0] got, din;
   logic [31:0] seed;
   int          err_total, samples_checked, cycles;
   logic [7:0]  byOps [4] = '{tap_pkg::IR_BYPASS, 8'h01, 8'h83, 8'hFE};
   logic [2:0]  opCode [8] = '{3'h1, 3'h2, 3'h3, 3'h6, 3'h0, 3'h4, 3'h5, 3'h7};
   scan_tap #(.IDCODE_VAL(ID_VAL)) dut (.clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
      .tdoOe(tdoOe), .bcIn(bcIn), .bcOut(bcOut), .testMode(testMode), .testRunning(testRunning));
   tap_host_model host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe));
   ////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Bypass puts one zero in front and delays by one bit
   function automatic logic [63:0] byExp(logic [63:0] d, int n);
      return (d << 1) & ((64'h1 << n) - 64'h1);
   endfunction
   function automatic logic [63:0] runs(logic [2:0] op);
      return {63'h0, op inside {3'h1, 3'h2, 3'h3, 3'h6}};
   endfunction
   task automatic check(input string what, input logic [63:0] exp, input logic [63:0] seen);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic irScan(input logic [7:0] op);
      host.scan(1'h1, {56'h0, op}, 8, got);
      check("ir capture", 64'h81, got);
   endtask
   // Flags cross to clk in two or three edges
   task automatic settle();
      repeat (4) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   // Clock, pin stimulus and hang guard
   initial begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end
   always @(negedge clk) bcIn <= 48'({rnd(), rnd()});
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         err_total++;
         $display("Error timeout expected done seen running");
         tally_and_finish();
      end
   end
   ////////////////////////////////////////
   // Main sequence
   initial begin
      seed = 32'h19;
      rst = 1'h1;
      bcIn = '0;
      fork
         host.run(20, 1'h1);
         repeat (10) @(posedge clk);
      join
      @(negedge clk) rst = 1'h0;
      // Long enough in reset for the checker to see eight reset cycles
      host.run(10, 1'h1);
      host.run(1, 1'h0);
      check("testMode", 64'h0, testMode);
      check("safe cells", 64'hF, bcOut[47:44]);
      host.scan(1'h0, rnd(), 32, got);
      check("ident", ID_VAL, got);
      $display("test reset done");
      foreach (byOps[k]) begin
         irScan(byOps[k]);
         din = {rnd(), rnd()};
         host.scan(1'h0, din, 16, got);
         check("bypass", byExp(din, 16), got);
      end
      $display("test bypass done");
      irScan(tap_pkg::IR_EXTEST);
      din = {rnd(), rnd()};
      host.scan(1'h0, din, 48, got);
      check("bcOut", din[47:0], bcOut);
      settle();
      check("testMode extest", 64'h1, testMode);
      irScan(tap_pkg::IR_SAMPLE);
      settle();
      check("testMode sample", 64'h0, testMode);
      $display("test boundary done");
      foreach (opCode[k]) begin
         irScan(tap_pkg::IR_BCRSCAN);
         host.scan(1'h0, opCode[k], 3, got);
         check("control", (k == 0) ? tap_pkg::BCR_RESET : opCode[(k + 7) % 8], got);
         irScan(tap_pkg::IR_RUNTEST);
         host.run(10, 1'h0);
         settle();
         check("testRunning", runs(opCode[k]), testRunning);
      end
      $display("test operations done");
      host.run(1, 1'h1);
      host.run(2, 1'h0);
      host.run(5, 1'h1); // Reset from inside a data shift
      host.run(1, 1'h0);
      settle();
      check("testMode tms reset", 64'h0, testMode);
      host.scan(1'h0, rnd(), 32, got);
      check("ident after reset", ID_VAL, got);
      irScan(tap_pkg::IR_BCRSCAN);
      host.scan(1'h0, 64'h5, 3, got);
      check("control after reset", tap_pkg::BCR_RESET, got);
      $display("test tms reset done");
      tally_and_finish();
   end
endmodule
